// ---- src/pbcsr_pkg.sv ----
package pbcsr_pkg;
    // register numbers on the management bus
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_HIGH = 5'h02;

    // control field positions
    localparam int CTL_SPEED = 13;
    localparam int CTL_AN_EN = 12;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COLL_TEST = 7;

    // control reset values (speed, duplex and negotiation enable come from straps)
    localparam logic CTL_ISOLATE_RST = 1'b0;
    localparam logic CTL_RESTART_RST = 1'b0;
    localparam logic CTL_COLL_TEST_RST = 1'b0;

    // status: capability bits 14..11, 6, 3 and 0 are fixed ones
    localparam logic [15:0] STATUS_FIXED = 16'h7849;
    localparam int STS_AN_DONE = 5;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_LINK = 2;
    localparam int STS_JABBER = 1;

    // first identifier word; value is arbitrary
    localparam logic [15:0] ID_HIGH_VALUE = 16'h5a3c;

    // management frame fields
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [5:0] PREAMBLE_LAST = 6'h1f;
    localparam logic [3:0] ADDR_LAST = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'hf;

    // strap settle count after reset release (covers the pin synchroniser)
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    // collision test timing at the fastest bit rate
    localparam int BIT_TIME_PS = 10000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int COL_ON_BIT_TIMES = 512;
    localparam int COL_OFF_BIT_TIMES = 4;
    localparam int COL_ON_CYCLES = COL_ON_BIT_TIMES * BIT_TIME_PS / CLK_PERIOD_PS;
    localparam int COL_OFF_CYCLES = COL_OFF_BIT_TIMES * BIT_TIME_PS / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_OP,
        S_ADDR,
        S_TA,
        S_DATA
    } pbcsr_state_t;
endpackage : pbcsr_pkg

// ---- src/pbcsr_pin_sync.sv ----
`timescale 1ns/1ps
module pbcsr_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and control
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // pins and filtered result
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_stable
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // stage1 is only read by stage2 to keep metastability contained
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    pin_stable[i] <= 1'b0;
                end else if (clk_en) begin
                    stage1[i] <= pin_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        pin_stable[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pbcsr_pin_sync

// ---- src/pbcsr_top.sv ----
`timescale 1ns/1ps
// Operation
// - control bit 10 isolates port from MAC data path; management stays usable
// - restart-negotiation write ignored while negotiation enable is zero
// - restart bit reads one until negotiation starts, then self-clears
// - writing zero to restart bit does not disturb running negotiation
// - control bit 8 selects duplex, strap default, writable
// - collision test asserts col within 512 bit times of tx_en rising
// - collision test drops col within 4 bit times of tx_en falling
// - status bit 15 always reads zero
// - status bits 14 to 11 read one: supported speed/duplex modes
// - status bit 6 reads one; preamble needed after reset or bad frame
// - status bit 5 reads one only once negotiation completed
// - remote fault bit latches high, cleared by read or reset
// - status bit 3 reads one: negotiation supported
// - link bit latches low on loss, returns one on later read
// - jabber bit latches high on jabber detection
// - status bit 0 reads one: extended registers present
// - with negotiation off, bits 8 and 13 set duplex and speed
// - latched fields hold their event value until read
module pbcsr_top (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // serial management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // MAC pins
    input wire logic tx_en,
    output logic col,
    // straps
    input wire logic [4:0] phy_addr_strap,
    input wire logic duplex_strap,
    input wire logic speed_strap,
    input wire logic an_enable_strap,
    // port core status
    input wire logic an_complete_in,
    input wire logic an_started,
    input wire logic link_up,
    input wire logic remote_fault_evt,
    input wire logic jabber_evt,
    // port core control
    output logic isolate,
    output logic an_enable,
    output logic an_restart,
    output logic duplex_full,
    output logic speed_100
);
    logic [10:0] pins_stable;
    logic mdc_s;
    logic smi_bit;
    logic tx_en_s;
    logic mdc_d;
    logic mdc_rise;
    pbcsr_pkg::pbcsr_state_t state;
    logic [5:0] ones_cnt;
    logic pre_ok;
    logic [3:0] bit_cnt;
    logic [1:0] op;
    logic [9:0] addr_sh;
    logic [15:0] data_sh;
    logic rd_hit;
    logic coll_test;
    logic rf_latched;
    logic jab_latched;
    logic link_latched;
    logic an_done;
    logic [4:0] phy_addr;
    logic [2:0] strap_cnt;
    logic strap_pending;

    pbcsr_pin_sync #(
        .WIDTH(11)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in({an_enable_strap, speed_strap, duplex_strap, phy_addr_strap, tx_en, mdio_in, mdc}),
        .pin_stable(pins_stable)
    );

    assign mdc_s = pins_stable[0];
    assign smi_bit = pins_stable[1];
    assign tx_en_s = pins_stable[2];
    assign mdc_rise = mdc_s & ~mdc_d;

    // frame decode
    wire [1:0] op_full = {op[0], smi_bit};
    wire op_valid = (op_full == pbcsr_pkg::OP_READ) || (op_full == pbcsr_pkg::OP_WRITE);
    wire [9:0] addr_full = {addr_sh[8:0], smi_bit};
    wire addr_edge = mdc_rise && (state == pbcsr_pkg::S_ADDR) && (bit_cnt == pbcsr_pkg::ADDR_LAST);
    wire addr_hit = addr_full[9:5] == phy_addr;
    wire rd_capture = addr_edge && (op == pbcsr_pkg::OP_READ) && addr_hit;
    wire rd_stat = rd_capture && (addr_full[4:0] == pbcsr_pkg::REG_STATUS);
    wire [15:0] wr_data = {data_sh[14:0], smi_bit};
    wire wr_done = mdc_rise && (state == pbcsr_pkg::S_DATA) && (bit_cnt == pbcsr_pkg::DATA_LAST)
        && (op == pbcsr_pkg::OP_WRITE) && (addr_sh[9:5] == phy_addr);
    wire wr_ctrl = wr_done && (addr_sh[4:0] == pbcsr_pkg::REG_CONTROL);
    // restart only arms while negotiation is already enabled
    wire restart_set = wr_ctrl && wr_data[pbcsr_pkg::CTL_RESTART] && an_enable;
    wire ta_bad = (bit_cnt == 4'd0) ? ~smi_bit : smi_bit;

    // read views
    wire [15:0] ctrl_word = {2'b00, speed_100, an_enable, 1'b0, isolate, an_restart, duplex_full,
        coll_test, 7'h00};
    wire [15:0] stat_word = pbcsr_pkg::STATUS_FIXED
        | {10'h000, an_done, rf_latched, 1'b0, link_latched, jab_latched, 1'b0};
    wire [15:0] rd_word = (addr_full[4:0] == pbcsr_pkg::REG_CONTROL) ? ctrl_word
        : (addr_full[4:0] == pbcsr_pkg::REG_STATUS) ? stat_word
        : (addr_full[4:0] == pbcsr_pkg::REG_ID_HIGH) ? pbcsr_pkg::ID_HIGH_VALUE
        : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mdc_d <= 1'b0;
        end else if (clk_en) begin
            mdc_d <= mdc_s;
        end
    end

    // management frame engine, advanced on each synchronised mdc rising edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= pbcsr_pkg::S_IDLE;
            ones_cnt <= 6'h00;
            pre_ok <= 1'b0;
            bit_cnt <= 4'h0;
            op <= 2'b00;
            addr_sh <= 10'h000;
            data_sh <= 16'h0000;
            rd_hit <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (clk_en && mdc_rise) begin
            case (state)
                pbcsr_pkg::S_IDLE: begin
                    mdio_oe <= 1'b0;
                    if (smi_bit) begin
                        if (ones_cnt == pbcsr_pkg::PREAMBLE_LAST) begin
                            pre_ok <= 1'b1;
                        end else begin
                            ones_cnt <= ones_cnt + 6'd1;
                        end
                    end else begin
                        ones_cnt <= 6'h00;
                        if (pre_ok) begin
                            state <= pbcsr_pkg::S_START;
                        end
                    end
                end
                pbcsr_pkg::S_START: begin
                    bit_cnt <= 4'h0;
                    state <= smi_bit ? pbcsr_pkg::S_OP : pbcsr_pkg::S_IDLE;
                end
                pbcsr_pkg::S_OP: begin
                    op <= op_full;
                    if (bit_cnt == 4'd0) begin
                        bit_cnt <= 4'd1;
                    end else if (op_valid) begin
                        bit_cnt <= 4'h0;
                        state <= pbcsr_pkg::S_ADDR;
                    end else begin
                        pre_ok <= 1'b0;
                        state <= pbcsr_pkg::S_IDLE;
                    end
                end
                pbcsr_pkg::S_ADDR: begin
                    addr_sh <= addr_full;
                    if (bit_cnt == pbcsr_pkg::ADDR_LAST) begin
                        bit_cnt <= 4'h0;
                        data_sh <= rd_word;
                        rd_hit <= rd_capture;
                        state <= pbcsr_pkg::S_TA;
                    end else begin
                        bit_cnt <= bit_cnt + 4'd1;
                    end
                end
                pbcsr_pkg::S_TA: begin
                    bit_cnt <= bit_cnt + 4'd1;
                    if (op == pbcsr_pkg::OP_WRITE && ta_bad) begin
                        // a broken turnaround loses sync; demand a fresh preamble
                        pre_ok <= 1'b0;
                        state <= pbcsr_pkg::S_IDLE;
                    end else if (bit_cnt == 4'd0) begin
                        mdio_oe <= rd_hit;
                        mdio_out <= 1'b0;
                    end else begin
                        mdio_out <= data_sh[15];
                        data_sh <= wr_data;
                        bit_cnt <= 4'h0;
                        state <= pbcsr_pkg::S_DATA;
                    end
                end
                pbcsr_pkg::S_DATA: begin
                    data_sh <= wr_data;
                    mdio_out <= data_sh[15];
                    bit_cnt <= bit_cnt + 4'd1;
                    if (bit_cnt == pbcsr_pkg::DATA_LAST) begin
                        mdio_oe <= 1'b0;
                        state <= pbcsr_pkg::S_IDLE;
                    end
                end
                default: begin
                    state <= pbcsr_pkg::S_IDLE;
                end
            endcase
        end
    end

    // straps are caught a few cycles after release, once the synchroniser has settled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_cnt <= 3'h0;
            strap_pending <= 1'b1;
            phy_addr <= 5'h00;
        end else if (clk_en && strap_pending) begin
            strap_cnt <= strap_cnt + 3'd1;
            if (strap_cnt == pbcsr_pkg::STRAP_SETTLE) begin
                strap_pending <= 1'b0;
                phy_addr <= pins_stable[7:3];
            end
        end
    end

    // control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            isolate <= pbcsr_pkg::CTL_ISOLATE_RST;
            coll_test <= pbcsr_pkg::CTL_COLL_TEST_RST;
            duplex_full <= 1'b0;
            speed_100 <= 1'b0;
            an_enable <= 1'b0;
        end else if (clk_en) begin
            if (strap_pending && strap_cnt == pbcsr_pkg::STRAP_SETTLE) begin
                duplex_full <= pins_stable[8];
                speed_100 <= pins_stable[9];
                an_enable <= pins_stable[10];
            end else if (wr_ctrl) begin
                isolate <= wr_data[pbcsr_pkg::CTL_ISOLATE];
                coll_test <= wr_data[pbcsr_pkg::CTL_COLL_TEST];
                duplex_full <= wr_data[pbcsr_pkg::CTL_DUPLEX];
                speed_100 <= wr_data[pbcsr_pkg::CTL_SPEED];
                an_enable <= wr_data[pbcsr_pkg::CTL_AN_EN];
            end
        end
    end

    // restart request: a written zero leaves it alone, the start acknowledge clears it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            an_restart <= pbcsr_pkg::CTL_RESTART_RST;
        end else if (clk_en) begin
            if (restart_set) begin
                an_restart <= 1'b1;
            end else if (an_started) begin
                an_restart <= 1'b0;
            end
        end
    end

    // latched status; a new event in the read cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rf_latched <= 1'b0;
            jab_latched <= 1'b0;
            link_latched <= 1'b0;
            an_done <= 1'b0;
            col <= 1'b0;
        end else if (clk_en) begin
            rf_latched <= remote_fault_evt | (rf_latched & ~rd_stat);
            jab_latched <= jabber_evt | (jab_latched & ~rd_stat);
            link_latched <= link_up & (link_latched | rd_stat);
            an_done <= an_complete_in & an_enable & ~an_restart;
            // col follows tx_en five cycles later, far inside the 1024-cycle on limit but only just inside the 8-cycle off limit
            col <= coll_test & tx_en_s & ~isolate;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !clk_en);

    // col is registered after isolate, so the check looks one cycle on
    isolate_view_a: assert property (
        (wr_ctrl && !strap_pending |=> isolate == $past(wr_data[pbcsr_pkg::CTL_ISOLATE]))
        and (isolate |=> !col))
        else $error("isolate not taken from write or col driven while isolated");
    restart_ignored_a: assert property (
        wr_ctrl && !an_enable && !an_restart |=> !an_restart)
        else $error("restart armed with negotiation disabled");
    restart_hold_a: assert property (an_restart && !an_started |=> an_restart)
        else $error("restart dropped before negotiation started");
    restart_clear_a: assert property (
        an_restart && an_started && !restart_set |=> !an_restart)
        else $error("restart did not self clear");
    restart_zero_a: assert property (
        wr_ctrl && !wr_data[pbcsr_pkg::CTL_RESTART] && an_restart && !an_started |=> an_restart)
        else $error("written zero cancelled restart");
    duplex_write_a: assert property (
        wr_ctrl && !strap_pending |=> duplex_full == $past(wr_data[pbcsr_pkg::CTL_DUPLEX])
        && speed_100 == $past(wr_data[pbcsr_pkg::CTL_SPEED]))
        else $error("duplex or speed not taken from write");
    col_rise_a: assert property (
        coll_test && !isolate && $rose(tx_en) |-> ##[1:8] col)
        else $error("col late after tx_en");
    col_fall_a: assert property ($fell(tx_en) |-> ##[1:8] !col)
        else $error("col held after tx_en fell");
    status_fixed_a: assert property (
        stat_word[15:11] == 5'h0f && stat_word[6] && stat_word[3] && stat_word[0])
        else $error("fixed status bits wrong");
    // the done flag is registered, so it answers to last cycle's enable and restart
    an_done_a: assert property (
        stat_word[5] |-> $past(an_enable) && !$past(an_restart) && $past(an_complete_in))
        else $error("negotiation done shown without completion");
    rf_latch_a: assert property (
        remote_fault_evt |=> rf_latched ##1 (rf_latched || $past(rd_stat)))
        else $error("remote fault not latched");
    link_low_a: assert property (
        !link_up |=> !link_latched ##1 (!link_latched || $past(rd_stat)))
        else $error("link loss not latched low");
    jab_latch_a: assert property (jabber_evt |=> jab_latched)
        else $error("jabber not latched");
    pre_lost_a: assert property (
        mdc_rise && state == pbcsr_pkg::S_OP && bit_cnt == 4'h1 && !op_valid |=> !pre_ok)
        else $error("bad opcode kept preamble sync");

    read_frame_c: cover property (rd_capture ##[1:200] (mdio_oe && state == pbcsr_pkg::S_DATA));
    write_frame_c: cover property (wr_ctrl);
    restart_cycle_c: cover property (an_restart && an_started ##1 !an_restart);
    col_test_c: cover property (coll_test && col);
endmodule : pbcsr_top

// ---- bench/pbcsr_smi_master.sv ----
`timescale 1ns/1ps
module pbcsr_smi_master (
    // clock
    input wire logic ref_clk,
    // device side of the data pin
    input wire logic mdio_out,
    input wire logic mdio_oe,
    // resolved pins
    output logic mdc,
    output logic mdio_line
);
    logic drv_en;
    logic drv_bit;
    // pull-up holds the line high when nobody drives
    assign mdio_line = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
    end
    // data moves while mdc is low; the line is taken just before the rise
    task automatic bit_cell(input logic b, output logic s);
        mdc = 1'b0;
        drv_bit = b;
        repeat (8) @(negedge ref_clk);
        s = mdio_line;
        mdc = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask : bit_cell
    // ta only matters for writes; a read releases the line from turnaround on
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [1:0] ta,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, op, pa, ra};
        drv_en = 1'b1;
        if (pre) begin
            repeat (32) bit_cell(1'b1, s);
        end
        for (int i = 13; i >= 0; i--) begin
            bit_cell(hdr[i], s);
        end
        drv_en = (op != pbcsr_pkg::OP_READ);
        bit_cell(ta[1], s);
        bit_cell(ta[0], s);
        for (int i = 15; i >= 0; i--) begin
            bit_cell(wd[i], s);
            rd[i] = s;
        end
        drv_en = 1'b0;
        // mdc parks low between frames; one cycle apart so a next frame never
        // re-drives the line in the same time step
        mdc = 1'b0;
        @(negedge ref_clk);
    endtask : frame
endmodule : pbcsr_smi_master

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic ref_clk, rst, clk_en, tx_en, an_complete_in, an_started, link_up;
    logic remote_fault_evt, jabber_evt, mdc, mdio_line, mdio_out, mdio_oe, col;
    logic isolate, an_enable, an_restart, duplex_full, speed_100;
    logic [15:0] v;
    int fails, tests_run;
    localparam logic [4:0] CTL = pbcsr_pkg::REG_CONTROL;
    localparam logic [4:0] STS = pbcsr_pkg::REG_STATUS;

    pbcsr_top dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .tx_en(tx_en),
        .col(col), .phy_addr_strap(5'h01), .duplex_strap(1'b1), .speed_strap(1'b1),
        .an_enable_strap(1'b1), .an_complete_in(an_complete_in), .an_started(an_started),
        .link_up(link_up), .remote_fault_evt(remote_fault_evt), .jabber_evt(jabber_evt),
        .isolate(isolate), .an_enable(an_enable), .an_restart(an_restart),
        .duplex_full(duplex_full), .speed_100(speed_100));
    pbcsr_smi_master mst (.ref_clk(ref_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_line(mdio_line));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic close_out;
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [4:0] ra, output logic [15:0] d,
                      input logic pre = 1'b0, input logic [4:0] pa = 5'h01);
        mst.frame(pre, pbcsr_pkg::OP_READ, pa, ra, 2'b11, 16'hffff, d);
    endtask : rd
    task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [1:0] ta = 2'b10);
        logic [15:0] x;
        mst.frame(1'b0, pbcsr_pkg::OP_WRITE, 5'h01, ra, ta, d, x);
    endtask : wr
    task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] d;
        rd(ra, d);
        chk(d, exp);
    endtask : rchk
    // col moves a few cycles after tx_en because the pin is synchronised
    task automatic col_within(input logic lvl);
        for (int i = 0; i < 8 && col !== lvl; i++) @(negedge ref_clk);
        chk({15'h0, col}, {15'h0, lvl});
    endtask : col_within

    task automatic t_lock;
        rd(CTL, v);
        chk(v, 16'hffff);
        rd(CTL, v, 1'b1);
        chk(v, 16'h3100);
        chk({11'h0, an_enable, duplex_full, speed_100, isolate, an_restart}, 16'h001c);
    endtask : t_lock
    task automatic t_status;
        rchk(STS, 16'h7869);
        rchk(STS, 16'h786d);
        link_up = 1'b0;
        repeat (3) @(negedge ref_clk);
        link_up = 1'b1;
        rchk(STS, 16'h7869);
        rchk(STS, 16'h786d);
    endtask : t_status
    task automatic t_latch;
        remote_fault_evt = 1'b1;
        jabber_evt = 1'b1;
        @(negedge ref_clk);
        remote_fault_evt = 1'b0;
        jabber_evt = 1'b0;
        rchk(STS, 16'h787f);
        rchk(STS, 16'h786d);
        // an event while the clock enable is low must leave no trace
        clk_en = 1'b0;
        jabber_evt = 1'b1;
        @(negedge ref_clk);
        clk_en = 1'b1;
        jabber_evt = 1'b0;
        rchk(STS, 16'h786d);
    endtask : t_latch
    task automatic t_restart;
        wr(CTL, 16'h3300);
        rchk(CTL, 16'h3300);
        chk({15'h0, an_restart}, 16'h0001);
        rchk(STS, 16'h784d);
        wr(CTL, 16'h3100);
        rchk(CTL, 16'h3300);
        an_started = 1'b1;
        @(negedge ref_clk);
        an_started = 1'b0;
        rchk(CTL, 16'h3100);
        chk({15'h0, an_restart}, 16'h0000);
        wr(CTL, 16'h2100);
        wr(CTL, 16'h2300);
        rchk(CTL, 16'h2100);
        rchk(STS, 16'h784d);
    endtask : t_restart
    task automatic t_forced;
        wr(CTL, 16'h0000);
        chk({14'h0, duplex_full, speed_100}, 16'h0000);
        wr(CTL, 16'h2100);
        chk({14'h0, duplex_full, speed_100}, 16'h0003);
    endtask : t_forced
    task automatic t_col;
        wr(CTL, 16'h0480);
        chk({15'h0, isolate}, 16'h0001);
        rchk(CTL, 16'h0480);
        tx_en = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk({15'h0, col}, 16'h0000);
        tx_en = 1'b0;
        wr(CTL, 16'h0080);
        tx_en = 1'b1;
        col_within(1'b1);
        tx_en = 1'b0;
        col_within(1'b0);
        wr(CTL, 16'h0000);
    endtask : t_col
    task automatic t_refuse;
        rchk(pbcsr_pkg::REG_ID_HIGH, pbcsr_pkg::ID_HIGH_VALUE);
        wr(pbcsr_pkg::REG_ID_HIGH, 16'h0000);
        rchk(pbcsr_pkg::REG_ID_HIGH, pbcsr_pkg::ID_HIGH_VALUE);
        wr(STS, 16'h0000);
        rchk(STS, 16'h784d);
        rchk(5'h07, 16'h0000);
        rd(CTL, v, 1'b0, 5'h02);
        chk(v, 16'hffff);
        wr(CTL, 16'h0100, 2'b11);
        rd(CTL, v);
        chk(v, 16'hffff);
        rd(CTL, v, 1'b1);
        chk(v, 16'h0000);
        mst.frame(1'b0, 2'b11, 5'h01, CTL, 2'b10, 16'h0100, v);
        rd(CTL, v);
        chk(v, 16'hffff);
        rd(CTL, v, 1'b1);
        chk(v, 16'h0000);
    endtask : t_refuse

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        tx_en = 1'b0;
        an_complete_in = 1'b1;
        an_started = 1'b0;
        link_up = 1'b1;
        remote_fault_evt = 1'b0;
        jabber_evt = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        t_lock();
        t_status();
        t_latch();
        t_restart();
        t_forced();
        t_col();
        t_refuse();
        close_out();
    end
    // about 40 frames of at most 64 bit cells at 16 cycles each fit well inside
    initial begin
        #300000;
        fails++;
        close_out();
    end
endmodule : tb
